// *** verification/pvi_checker.sv ***
/*
 * assertion checker for the vectoring controller, bound to its top module.
 * assumes the package is compiled first and sees only the top ports.
 */
`timescale 1ns/1ps
module pvi_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core side
    input wire pvi_pkg::pvi_core_t core_i,
    input wire pvi_pkg::pvi_call_t call_o,
    input wire logic [2:0] in_service_o,
    input wire logic [1:0] phase_o
);
    import pvi_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // call sequencing against the core handshake
    a_phase_wrap: assert property (phase_o == PH_C4 |=> phase_o == PH_C1)
        else $error("phase did not wrap");
    a_call_poll: assert property (call_o.start |-> $past(phase_o) == PH_C4 && $past(core_i.last_mc))
        else $error("call outside a last cycle poll");
    a_call_allowed: assert property (call_o.start |-> !$past(core_i.reg_write) && !$past(core_i.reti))
        else $error("call after a blocking instruction");
    a_tier_rises: assert property (call_o.start |-> $onehot(in_service_o ^ $past(in_service_o)) &&
        (in_service_o ^ $past(in_service_o)) > $past(in_service_o))
        else $error("call without a higher tier");
    a_load_time: assert property (call_o.start |-> ##16 call_o.load)
        else $error("vector load off time");
    a_busy_hold: assert property (call_o.start |=> call_o.busy [*8])
        else $error("busy dropped early");
    a_no_restart: assert property (call_o.start |=> !call_o.start [*8])
        else $error("second call inside a call");
    a_end_by_reti: assert property (|($past(in_service_o) & ~in_service_o) |->
        $past(core_i.reti) && $past(core_i.last_mc) && $past(phase_o) == PH_C4)
        else $error("in service ended without return");
    // main scenarios reached
    c_call: cover property (call_o.start);
    c_preempt: cover property (call_o.start && $past(in_service_o) != 3'h0);
    c_reti: cover property ($fell(in_service_o[0]));
endmodule : pvi_checker

bind pvi_ctrl pvi_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .core_i(core_i), .call_o(call_o),
    .in_service_o(in_service_o), .phase_o(phase_o));

// *** verification/pvi_core_model.sv ***
/*
 * core stand-in: marks machine cycles and instruction kinds, loads the vector.
 * assumes the controller's phase and call outputs.
 */
`timescale 1ns/1ps
module pvi_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // controller side
    input wire logic [1:0] phase_i,
    input wire pvi_pkg::pvi_call_t call_i,
    output pvi_pkg::pvi_core_t core_o,
    // bench controls
    input wire logic [1:0] mc_len_i,
    input wire logic write_i,
    input wire logic reti_i,
    // program counter
    output logic [15:0] pc_o
);
    import pvi_pkg::*;
    logic [1:0] mc_cnt;
    logic [1:0] next_cnt;
    assign next_cnt = core_o.last_mc ? 2'h0 : mc_cnt + 2'h1;
    // instruction kind held for a whole machine cycle
    // cycle and kind
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mc_cnt <= 2'h0;
            core_o <= '0;
        end else if (phase_i == PH_C4) begin
            mc_cnt <= next_cnt;
            core_o.last_mc <= next_cnt >= mc_len_i - 2'h1;
            core_o.reg_write <= write_i;
            core_o.reti <= reti_i;
        end
    end
    // counter takes the vector at the end of the call
    // vector load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= 16'h0000;
        end else if (call_i.load) begin
            pc_o <= call_i.vector;
        end
    end
endmodule : pvi_core_model

// *** verification/testbench.sv ***
/*
 * self-checking bench: registers, ordering, preemption, pins, timer and gating.
 * assumes package, controller, checker and core model compile first.
 */
`timescale 1ns/1ps
module testbench;
    import pvi_pkg::*;
    localparam logic [15:0] PF_VEC = 16'h0070;
    logic clk_i;
    logic rst_i;
    logic cyc, stb, we, ack, pfail, s0r, s1r, t2o, wdog, wr_kind, reti_kind;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] wdat, dout, rdat;
    logic [5:0] pins_n;
    logic [1:0] tmr, mc_len, phase;
    logic [2:0] isv;
    logic [15:0] pc;
    pvi_core_t core;
    pvi_call_t call;
    int mismatches, checked, n;
    pvi_ctrl #(.PFAIL_VECTOR(PF_VEC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .ext_request_pin_n_i(pins_n), .power_fail_request_i(pfail), .timer_overflow_i(tmr),
        .serial0_receive_flag_i(s0r), .serial0_transmit_flag_i(1'b0), .serial1_receive_flag_i(s1r),
        .serial1_transmit_flag_i(1'b0), .timer_two_overflow_flag_i(t2o), .timer_two_external_flag_i(1'b0),
        .watchdog_timeout_flag_i(wdog), .core_i(core), .call_o(call), .in_service_o(isv), .phase_o(phase));
    pvi_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .phase_i(phase), .call_i(call), .core_o(core),
        .mc_len_i(mc_len), .write_i(wr_kind), .reti_i(reti_kind), .pc_o(pc));
    // core clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // compare and count
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one classic bus cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk("ack", 1, ack);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task mc(input int k);
        repeat (k * CLK_PER_MC) @(posedge clk_i);
    endtask : mc
    // wait for the vector load, then check vector and counter
    task expect_call(input logic [15:0] exp);
        n = 0;
        while (call.load !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("call seen", 1, n < 300);
        @(posedge clk_i);
        chk("vector", exp, call.vector);
        chk("counter", exp, pc);
    endtask : expect_call
    // no call may start for k machine cycles
    task quiet(input int k);
        int c;
        c = 0;
        repeat (k * CLK_PER_MC) begin
            @(posedge clk_i);
            if (call.start === 1'b1) c++;
        end
        chk("calls", 0, c);
    endtask : quiet
    // one return instruction of one machine cycle
    task do_reti;
        reti_kind <= 1'b1;
        do @(posedge clk_i); while (phase !== PH_C4);
        reti_kind <= 1'b0;
        mc(2);
    endtask : do_reti
    task t_regs;
        wb(1'b0, ADR_ENABLE, 32'h0);
        chk("enable", 32'h0, rdat);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rdat);
        wb(1'b1, ADR_PRIO, 32'h0000_0FFF);
        wb(1'b0, ADR_PRIO, 32'h0);
        chk("prio", 32'h0000_0FFF, rdat);
        wb(1'b1, ADR_PRIO, 32'h0);
        $display("registers test done");
    endtask : t_regs
    task t_order;
        static logic [15:0] vecs [4] = '{16'h0023, 16'h002B, 16'h003B, 16'h0063};
        static int idx [4] = '{4, 5, 6, 11};
        wb(1'b1, ADR_ENABLE, 32'h0000_8FFF);
        {wdog, s1r, t2o, s0r} <= 4'hF;
        for (int k = 0; k < 4; k++) begin
            expect_call(vecs[k]);
            wb(1'b0, ADR_FLAGS, 32'h0);
            chk("level flag", 1, rdat[idx[k]]);
            {wdog, s1r, t2o, s0r} <= 4'hF << (k + 1);
            do_reti();
        end
        chk("idle", 3'h0, isv);
        $display("order test done");
    endtask : t_order
    task t_preempt;
        wb(1'b1, ADR_PRIO, 32'h0000_0800);
        s0r <= 1'b1;
        expect_call(16'h0023);
        chk("low busy", 3'h1, isv);
        wdog <= 1'b1;
        expect_call(16'h0063);
        chk("both busy", 3'h3, isv);
        wdog <= 1'b0;
        quiet(4);
        do_reti();
        chk("high ended", 3'h1, isv);
        quiet(4);
        s0r <= 1'b0;
        do_reti();
        wb(1'b1, ADR_PRIO, 32'h0);
        $display("preempt test done");
    endtask : t_preempt
    task t_pins;
        wb(1'b1, ADR_CFG, 32'h5);
        pins_n[0] <= 1'b0;
        expect_call(16'h0003);
        wb(1'b0, ADR_FLAGS, 32'h0);
        chk("edge flag", 0, rdat[0]);
        pins_n[0] <= 1'b1;
        do_reti();
        pins_n[1] <= 1'b0;
        expect_call(16'h0013);
        wb(1'b0, ADR_FLAGS, 32'h0);
        chk("level pin flag", 1, rdat[2]);
        pins_n[1] <= 1'b1;
        do_reti();
        pins_n[2] <= 1'b0;
        expect_call(16'h0043);
        wb(1'b0, ADR_FLAGS, 32'h0);
        chk("hw cleared flag", 0, rdat[7]);
        pins_n[2] <= 1'b1;
        do_reti();
        do @(posedge clk_i); while (phase !== 2'h1);
        tmr[0] <= 1'b1;
        @(posedge clk_i);
        tmr[0] <= 1'b0;
        expect_call(16'h000B);
        chk("latency floor", 1, n + 1 >= MIN_LAT_MC * CLK_PER_MC);
        chk("latency ceiling", 1, n + 1 <= MAX_LAT_CLK);
        wb(1'b0, ADR_FLAGS, 32'h0);
        chk("timer flag", 0, rdat[1]);
        do_reti();
        $display("pins test done");
    endtask : t_pins
    task t_gate;
        wr_kind <= 1'b1;
        mc(1);
        s0r <= 1'b1;
        quiet(3);
        s0r <= 1'b0;
        wr_kind <= 1'b0;
        quiet(6);
        mc_len <= 2'h3;
        s0r <= 1'b1;
        expect_call(16'h0023);
        s0r <= 1'b0;
        mc_len <= 2'h1;
        do_reti();
        wb(1'b1, ADR_ENABLE, 32'h0000_1010);
        s0r <= 1'b1;
        quiet(4);
        pfail <= 1'b1;
        expect_call(PF_VEC);
        chk("top busy", 3'h4, isv);
        pfail <= 1'b0;
        s0r <= 1'b0;
        do_reti();
        chk("all idle", 3'h0, isv);
        $display("gate test done");
    endtask : t_gate
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // reset, then the scenarios in turn
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, pfail, s0r, s1r, t2o, wdog, wr_kind, reti_kind} = '0;
        sel = 4'hF;
        adr = 8'h00;
        wdat = 32'h0;
        pins_n = 6'h3F;
        tmr = 2'h0;
        mc_len = 2'h1;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_order();
        t_preempt();
        t_pins();
        t_gate();
        report_and_stop();
    end
    // scenarios need under a thousand cycles; this is over ten times that
    initial begin
        #60000;
        mismatches++;
        report_and_stop();
    end
endmodule : testbench

// *** verilog/pvi_ctrl.sv ***
/*
 * priority interrupt vectoring controller with wishbone register port.
 * assumes the core reports its last machine cycle, enable/priority writes and returns,
 * and performs the stack push and counter load when told.
 */
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module pvi_ctrl #(
    parameter logic [15:0] PFAIL_VECTOR = 16'h0070
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // request pins, external ones active low, power fail active high
    input wire logic [5:0] ext_request_pin_n_i,
    input wire logic power_fail_request_i,
    // peripheral requests
    input wire logic [1:0] timer_overflow_i,
    input wire logic serial0_receive_flag_i,
    input wire logic serial0_transmit_flag_i,
    input wire logic serial1_receive_flag_i,
    input wire logic serial1_transmit_flag_i,
    input wire logic timer_two_overflow_flag_i,
    input wire logic timer_two_external_flag_i,
    input wire logic watchdog_timeout_flag_i,
    // processor core
    input wire pvi_pkg::pvi_core_t core_i,
    output pvi_pkg::pvi_call_t call_o,
    output logic [2:0] in_service_o,
    output logic [1:0] phase_o
);
    import pvi_pkg::*;

    logic c1;
    logic c3;
    logic c4;
    logic [5:0] pin_sample;
    logic [5:0] pin_fall;
    logic [11:0] source_enable_reg;
    logic global_irq_enable;
    logic pfail_enable;
    logic [11:0] priority_select_reg;
    logic [1:0] ext_edge_mode;
    logic [3:0] hw_flag_clear_select;
    logic [5:0] ext_flag;
    logic [1:0] timer_flag;
    logic [11:0] request;
    logic [11:0] snap;
    logic snap_pfail;
    logic [4:0] hi_pick;
    logic [4:0] lo_pick;
    logic cand;
    logic [1:0] cand_tier;
    logic [3:0] cand_idx;
    logic tier_free;
    logic take;
    logic [3:0] last_idx;
    pvi_state_t state;
    logic [1:0] call_mc;
    logic [5:0] ext_hw_clear;
    logic [1:0] timer_hw_clear;
    logic wb_req;
    logic wb_wr;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic flags_wr;
    logic call_start;
    logic call_busy;
    logic call_load;
    logic [15:0] call_vector;

    // machine cycle phases
    pvi_phase u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(phase_o),
        .c1_o(c1),
        .c3_o(c3),
        .c4_o(c4)
    );

    for (genvar g = 0; g < 6; g++) begin : g_pin
        pvi_pin_sample u_pin (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .c3_i(c3),
            .pin_i(ext_request_pin_n_i[g]),
            .sample_o(pin_sample[g]),
            .fall_o(pin_fall[g])
        );
    end

    // bus request decode and byte lanes
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land on the edge at which the master sees ack
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign flags_wr = wb_wr & (wb_adr_i == ADR_FLAGS);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_enable_reg <= EN_RESET;
            pfail_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (wb_wr && wb_adr_i == ADR_ENABLE) begin
            source_enable_reg <= (source_enable_reg & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
            if (wb_sel_i[1]) begin
                pfail_enable <= wb_dat_i[PFAIL_EN_BIT];
                global_irq_enable <= wb_dat_i[GLOBAL_EN_BIT];
            end
        end
    end

    // tier select per source, one means high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            priority_select_reg <= PRIO_RESET;
        end else if (wb_wr && wb_adr_i == ADR_PRIO) begin
            priority_select_reg <= (priority_select_reg & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
        end
    end

    // trigger mode and hardware clear selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {hw_flag_clear_select, ext_edge_mode} <= CFG_RESET;
        end else if (wb_wr && wb_adr_i == ADR_CFG && wb_sel_i[0]) begin
            {hw_flag_clear_select, ext_edge_mode} <= wb_dat_i[5:0];
        end
    end

    // hardware flag clears on vectoring
    always_comb begin
        ext_hw_clear = 6'h00;
        timer_hw_clear = 2'h0;
        if (take && cand_tier != 2'(TIER_TOP)) begin
            // external zero/one only when edge triggered
            ext_hw_clear[0] = (cand_idx == SRC_EXT0) & ext_edge_mode[0];
            ext_hw_clear[1] = (cand_idx == SRC_EXT1) & ext_edge_mode[1];
            for (int k = 0; k < 4; k++) begin
                ext_hw_clear[k + 2] = (cand_idx == 4'(k + 7)) & hw_flag_clear_select[k];
            end
            timer_hw_clear[0] = (cand_idx == SRC_TMR0);
            timer_hw_clear[1] = (cand_idx == SRC_TMR1);
        end
    end

    // external request flags; a new edge beats any clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_flag <= 6'h00;
        end else begin
            for (int k = 0; k < 6; k++) begin
                if (k < 2 && !ext_edge_mode[k % 2]) begin
                    // level mode follows the sampled pin
                    ext_flag[k] <= ~pin_sample[k];
                end else begin
                    ext_flag[k] <= ((flags_wr && wb_sel_i[(k < 2 ? k * 2 : k + 5) / 8])
                        ? wb_dat_i[k < 2 ? k * 2 : k + 5] : ext_flag[k]) & ~ext_hw_clear[k] | pin_fall[k];
                end
            end
        end
    end

    // timer flags, set by the phase-three overflow pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_flag <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                timer_flag[k] <= ((flags_wr && wb_sel_i[0])
                    ? wb_dat_i[k * 2 + 1] : timer_flag[k]) & ~timer_hw_clear[k] | timer_overflow_i[k];
            end
        end
    end

    // peripheral flags used as given, never cleared here
    assign request = {watchdog_timeout_flag_i, ext_flag[5:2],
        serial1_receive_flag_i | serial1_transmit_flag_i,
        timer_two_overflow_flag_i | timer_two_external_flag_i,
        serial0_receive_flag_i | serial0_transmit_flag_i,
        timer_flag[1], ext_flag[1], timer_flag[0], ext_flag[0]};

    // fresh sample every machine cycle, nothing kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap <= 12'h000;
            snap_pfail <= 1'b0;
        end else if (c1) begin
            snap <= request & source_enable_reg & {NUM_SRC{global_irq_enable}};
            snap_pfail <= power_fail_request_i & pfail_enable;
        end
    end

    // lowest set index with a found flag on top
    function automatic logic [4:0] first_set(input logic [11:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction : first_set

    assign hi_pick = first_set(snap & priority_select_reg);
    assign lo_pick = first_set(snap & ~priority_select_reg);

    always_comb begin
        cand = 1'b1;
        cand_tier = 2'(TIER_TOP);
        cand_idx = SRC_PFAIL;
        if (!snap_pfail) begin
            if (hi_pick[4]) begin
                cand_tier = 2'(TIER_HIGH);
                cand_idx = hi_pick[3:0];
            end else begin
                cand = lo_pick[4];
                cand_tier = 2'(TIER_LOW);
                cand_idx = lo_pick[3:0];
            end
        end
    end

    // only if no equal or higher tier in service
    always_comb begin
        unique case (cand_tier)
            2'(TIER_TOP): tier_free = ~in_service_o[TIER_TOP];
            2'(TIER_HIGH): tier_free = ~|in_service_o[2:1];
            default: tier_free = ~|in_service_o;
        endcase
    end

    // poll at phase four of the last machine cycle
    assign take = c4 & (state == ST_RUN) & cand & tier_free
        & core_i.last_mc & ~core_i.reg_write & ~core_i.reti;

    // call state, four machine cycles long
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RUN;
            call_mc <= 2'h0;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (take) begin
                        state <= ST_CALL;
                        call_mc <= 2'h0;
                    end
                end
                ST_CALL: begin
                    if (c4) begin
                        call_mc <= call_mc + 2'h1;
                        if (call_mc == CALL_LAST) begin
                            state <= ST_RUN;
                        end
                    end
                end
            endcase
        end
    end

    // push request, then vector load at the end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            call_start <= 1'b0;
            call_load <= 1'b0;
            call_vector <= 16'h0000;
            last_idx <= 4'h0;
        end else begin
            call_start <= take;
            call_load <= (state == ST_CALL) & c4 & (call_mc == CALL_LAST);
            if (take) begin
                call_vector <= (cand_tier == 2'(TIER_TOP)) ? PFAIL_VECTOR : VEC_TABLE[cand_idx];
                last_idx <= cand_idx;
            end
        end
    end

    // busy follows the call state
    assign call_busy = (state == ST_CALL);

    // call carrier towards the core, one driver for the whole struct
    assign call_o = '{
        start: call_start,
        busy: call_busy,
        load: call_load,
        vector: call_vector
    };

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_service_o <= 3'h0;
        end else if (take) begin
            in_service_o[cand_tier] <= 1'b1;
        end else if (c4 && state == ST_RUN && core_i.last_mc && core_i.reti) begin
            // only the interrupt return ends the highest one
            if (in_service_o[TIER_TOP]) begin
                in_service_o[TIER_TOP] <= 1'b0;
            end else if (in_service_o[TIER_HIGH]) begin
                in_service_o[TIER_HIGH] <= 1'b0;
            end else begin
                in_service_o[TIER_LOW] <= 1'b0;
            end
        end
    end

    // read data selection, unmapped reads zero
    always_comb begin
        unique case (wb_adr_i)
            ADR_ENABLE: rd_word = {16'h0000, global_irq_enable, 2'h0, pfail_enable, source_enable_reg};
            ADR_PRIO: rd_word = {20'h00000, priority_select_reg};
            ADR_CFG: rd_word = {26'h0000000, hw_flag_clear_select, ext_edge_mode};
            ADR_FLAGS: rd_word = {19'h00000, power_fail_request_i, request};
            ADR_STATUS: rd_word = {24'h000000, last_idx, call_busy, in_service_o};
            default: rd_word = 32'h00000000;
        endcase
    end

    // single-wait acknowledge and registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_word;
            end
        end
    end
endmodule : pvi_ctrl

// *** verilog/pvi_phase.sv ***
/*
 * machine cycle phase divider.
 * assumes the core clock; phases run from reset release.
 */
`timescale 1ns/1ps
module pvi_phase (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // phase enables
    output logic [1:0] phase_o,
    output logic c1_o,
    output logic c3_o,
    output logic c4_o
);
    import pvi_pkg::*;

    // free running phase count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_o <= PH_C1;
        end else begin
            phase_o <= phase_o + 2'h1;
        end
    end

    // one-clock enables for phases one, three and four
    assign c1_o = (phase_o == PH_C1);
    assign c3_o = (phase_o == PH_C3);
    assign c4_o = (phase_o == PH_C4);
endmodule : pvi_phase

// *** verilog/pvi_pin_sample.sv ***
/*
 * request pin sampler with falling edge detection.
 * assumes a pin synchronous to the clock, sampled on the phase-three enable.
 */
`timescale 1ns/1ps
module pvi_pin_sample (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sampling
    input wire logic c3_i,
    input wire logic pin_i,
    // results
    output logic sample_o,
    output logic fall_o
);
    // pin level held once per machine cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_o <= 1'b1;
        end else if (c3_i) begin
            sample_o <= pin_i;
        end
    end

    // high sample followed by low sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fall_o <= 1'b0;
        end else begin
            fall_o <= c3_i & sample_o & ~pin_i;
        end
    end
endmodule : pvi_pin_sample

// *** verilog/pvi_pkg.sv ***
/*
 * constants, register map and carrier types of the priority interrupt vectoring block.
 * assumes one core clock with four clocks to a machine cycle and a classic wishbone register port.
 */
package pvi_pkg;
    // machine cycle timing
    localparam int CLK_PER_MC = 4;
    localparam logic [1:0] PH_C1 = 2'h0;
    localparam logic [1:0] PH_C3 = 2'h2;
    localparam logic [1:0] PH_C4 = 2'h3;
    localparam int CALL_MC = 4;
    localparam int MIN_LAT_MC = 5;
    localparam int MAX_LAT_MC = 12;
    localparam int MAX_LAT_CLK = MAX_LAT_MC * CLK_PER_MC;
    localparam logic [1:0] CALL_LAST = 2'(CALL_MC - 1);

    // source numbering, lowest index wins a tie
    localparam int NUM_SRC = 12;
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TMR0 = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TMR1 = 4'h3;
    localparam logic [3:0] SRC_PFAIL = 4'hC;

    // vector addresses by source index
    localparam logic [11:0][15:0] VEC_TABLE = {
        16'h0063, 16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h003B,
        16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

    // tier indices of the in-service vector
    localparam int TIER_LOW = 0;
    localparam int TIER_HIGH = 1;
    localparam int TIER_TOP = 2;

    // register byte offsets
    localparam logic [7:0] ADR_ENABLE = 8'h00;
    localparam logic [7:0] ADR_PRIO = 8'h04;
    localparam logic [7:0] ADR_CFG = 8'h08;
    localparam logic [7:0] ADR_FLAGS = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;

    // field positions
    localparam int PFAIL_EN_BIT = 12;
    localparam int GLOBAL_EN_BIT = 15;
    localparam int CFG_HC_LSB = 2;

    // values after reset
    localparam logic [11:0] EN_RESET = 12'h000;
    localparam logic [11:0] PRIO_RESET = 12'h000;
    localparam logic [5:0] CFG_RESET = 6'h00;

    // core handshake into the controller
    typedef struct packed {
        logic last_mc;
        logic reg_write;
        logic reti;
    } pvi_core_t;

    // hardware long call towards the core
    typedef struct packed {
        logic start;
        logic busy;
        logic load;
        logic [15:0] vector;
    } pvi_call_t;

    typedef enum logic [0:0] {ST_RUN, ST_CALL} pvi_state_t;
endpackage : pvi_pkg
